// file: verilog/tre_consts.vh
// constants and register map for the tag ram error bank and debug access
// Functional notes
// - error entry bits 23:16 report ways, four bits per processor
// - error entry bits 13:5 report the tag ram index of the error
// - status 1:0: 00 none, 01 tag ram only, 10 both, 11 confirmed
// - second error entry register, same layout as the first
// - error entries and ecc chunk register exist only with ecc built in
// - debug path reaches any tag location and can inject fake errors
// - operation bits 31:30 select the tag ram way
// - operation bit 24 selects processor 0 or processor 1 tag ram
// - operation bits 13:5 give the set index
// - operation bit 0: 0 read, 1 write
// - data value: valid bit 22, tag 21:17, width per cache size
// - ecc chunk register carries the check value in bits 6:0
`ifndef TRE_CONSTS_VH
`define TRE_CONSTS_VH
`define TRE_OFF_ERR_FIRST 12'h000
`define TRE_OFF_ERR_SECOND 12'h004
`define TRE_OFF_DBG_OP 12'h008
`define TRE_OFF_DBG_DATA 12'h00C
`define TRE_OFF_DBG_ECC 12'h010
`define TRE_OFF_IRQ_STAT 12'h014
`define TRE_OFF_IRQ_MASK 12'h018
`define TRE_ERR_MASK 32'h00FF3FE3
`define TRE_OP_MASK 32'hC1003FE1
`define TRE_DATA_MASK 32'h007E0000
`define TRE_ECC_MASK 32'h0000007F
`define TRE_WAY_HI 31
`define TRE_WAY_LO 30
`define TRE_CPU_BIT 24
`define TRE_IDX_HI 13
`define TRE_IDX_LO 5
`define TRE_DIR_BIT 0
`define TRE_VALID_BIT 22
`define TRE_TAG_HI 21
`define TRE_TAG_LO 17
`define TRE_ECC_HI 6
`define TRE_WAYS_LO 16
`define TRE_ST_NONE 2'h0
`define TRE_ST_TAGRAM 2'h1
`define TRE_ST_BOTH 2'h2
`define TRE_ST_CONFIRM 2'h3
`define TRE_RST_ZERO 32'h00000000
`define TRE_RST_MASK 4'h0
`define TRE_RAM_LAT 2'h2
`endif

// file: verilog/tre_bank.v
// tag ram error bank and debug access registers behind an apb slave
`timescale 1ns/1ps
`include "tre_consts.vh"
module tre_bank #(
   parameter ECC_PRESENT = 1
) (
   input wire clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // error events from the coherency unit tag ram
   input wire err_det,
   input wire err_cpu_seen,
   input wire [7:0] err_ways,
   input wire [8:0] err_index,
   // debug port to the coherency unit tag ram
   output reg ram_req,
   output reg ram_wr,
   output reg ram_cpu,
   output reg [1:0] ram_way,
   output reg [8:0] ram_index,
   output reg ram_valid_wr,
   output reg [4:0] ram_tag_wr,
   output reg [6:0] ram_ecc_wr,
   input wire ram_ack,
   input wire ram_valid_rd,
   input wire [4:0] ram_tag_rd,
   input wire [6:0] ram_ecc_rd,
   output reg irq
);
   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_DONE = 2'h2;
   reg [31:0] err_reg [0:1];
   reg [31:0] op_reg;
   reg [31:0] data_reg;
   reg [31:0] ecc_reg;
   reg [3:0] stat_reg;
   reg [3:0] mask_reg;
   reg [1:0] state_reg;
   reg [31:0] rd_next;
   reg unmapped;
   wire acc = psel & penable & ~pready;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire op_wr = wr & (paddr == `TRE_OFF_DBG_OP);
   wire ecc_ok = (ECC_PRESENT != 0);
   // events: error logged, entry lost (both full), debug done, debug write started
   wire slot0_free = err_reg[0][1:0] == `TRE_ST_NONE;
   wire slot1_free = err_reg[1][1:0] == `TRE_ST_NONE;
   wire [3:0] ev;
   wire stat_rd = rd & (paddr == `TRE_OFF_IRQ_STAT);
   assign ev[0] = err_det & ecc_ok & (slot0_free | slot1_free);
   assign ev[1] = err_det & ecc_ok & ~slot0_free & ~slot1_free;
   assign ev[2] = (state_reg == ST_WAIT) & ram_ack;
   assign ev[3] = op_wr & pwdata[`TRE_DIR_BIT] & ecc_ok;
   // apb read mux, unmapped and absent registers answer with an error
   always @* begin
      rd_next = `TRE_RST_ZERO;
      unmapped = 1'b0;
      case (paddr)
         `TRE_OFF_ERR_FIRST: begin
            rd_next = err_reg[0];
            unmapped = ~ecc_ok;
         end
         `TRE_OFF_ERR_SECOND: begin
            rd_next = err_reg[1];
            unmapped = ~ecc_ok;
         end
         `TRE_OFF_DBG_OP: rd_next = op_reg;
         `TRE_OFF_DBG_DATA: rd_next = data_reg;
         `TRE_OFF_DBG_ECC: begin
            rd_next = ecc_reg;
            unmapped = ~ecc_ok;
         end
         `TRE_OFF_IRQ_STAT: rd_next = {28'h0000000, stat_reg};
         `TRE_OFF_IRQ_MASK: rd_next = {28'h0000000, mask_reg};
         default: unmapped = 1'b1;
      endcase
   end
   // one wait state: pready rises in the cycle after the first access cycle
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `TRE_RST_ZERO;
      end else begin
         pready <= acc;
         pslverr <= acc & unmapped;
         prdata <= (rd & ~unmapped) ? rd_next : `TRE_RST_ZERO;
      end
   end
   // error bank: hardware logs into the first free entry, software may
   // rewrite status to confirm or clear; a new error beats a clear
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_err
         wire is_free = (err_reg[g][1:0] == `TRE_ST_NONE);
         wire take = err_det & ecc_ok & is_free & ((g == 0) | ~slot0_free);
         wire sw_wr = wr & ecc_ok & (paddr == (g == 0 ?
            `TRE_OFF_ERR_FIRST : `TRE_OFF_ERR_SECOND));
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               err_reg[g] <= `TRE_RST_ZERO;
            end else if (take) begin
               err_reg[g] <= {8'h00, err_ways, 2'h0, err_index, 3'h0,
                  err_cpu_seen ? `TRE_ST_BOTH : `TRE_ST_TAGRAM};
            end else if (err_reg[g][1:0] == `TRE_ST_TAGRAM && err_cpu_seen &&
                  !err_det) begin
               err_reg[g][1:0] <= `TRE_ST_BOTH;
            end else if (sw_wr) begin
               err_reg[g] <= pwdata & `TRE_ERR_MASK;
            end
         end
      end
   endgenerate
   // debug registers and access sequencer
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         op_reg <= `TRE_RST_ZERO;
         data_reg <= `TRE_RST_ZERO;
         ecc_reg <= `TRE_RST_ZERO;
         state_reg <= ST_IDLE;
         ram_req <= 1'b0;
         ram_wr <= 1'b0;
         ram_cpu <= 1'b0;
         ram_way <= 2'h0;
         ram_index <= 9'h000;
         ram_valid_wr <= 1'b0;
         ram_tag_wr <= 5'h00;
         ram_ecc_wr <= 7'h00;
      end else begin
         if (wr && paddr == `TRE_OFF_DBG_DATA) begin
            data_reg <= pwdata & `TRE_DATA_MASK;
         end
         if (wr && ecc_ok && paddr == `TRE_OFF_DBG_ECC) begin
            ecc_reg <= pwdata & `TRE_ECC_MASK;
         end
         case (state_reg)
            ST_IDLE: begin
               if (op_wr) begin
                  op_reg <= pwdata & `TRE_OP_MASK;
                  ram_req <= 1'b1;
                  ram_way <= pwdata[`TRE_WAY_HI:`TRE_WAY_LO];
                  ram_cpu <= pwdata[`TRE_CPU_BIT];
                  ram_index <= pwdata[`TRE_IDX_HI:`TRE_IDX_LO];
                  ram_wr <= pwdata[`TRE_DIR_BIT];
                  // a chosen chunk that mismatches the tag injects an error
                  ram_valid_wr <= data_reg[`TRE_VALID_BIT];
                  ram_tag_wr <= data_reg[`TRE_TAG_HI:`TRE_TAG_LO];
                  ram_ecc_wr <= ecc_reg[`TRE_ECC_HI:0];
                  state_reg <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (ram_ack) begin
                  ram_req <= 1'b0;
                  if (!ram_wr) begin
                     data_reg <= {9'h000, ram_valid_rd, ram_tag_rd,
                        17'h00000};
                     if (ecc_ok) begin
                        ecc_reg <= {25'h0000000, ram_ecc_rd};
                     end
                  end
                  state_reg <= ST_DONE;
               end
            end
            ST_DONE: state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
   // sticky status, cleared by reading it; a same-cycle event survives
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_reg <= `TRE_RST_MASK;
         mask_reg <= `TRE_RST_MASK;
         irq <= 1'b0;
      end else begin
         stat_reg <= (stat_rd ? 4'h0 : stat_reg) | ev;
         if (wr && paddr == `TRE_OFF_IRQ_MASK) begin
            mask_reg <= pwdata[3:0];
         end
         irq <= |(((stat_rd ? 4'h0 : stat_reg) | ev) & mask_reg);
      end
   end
endmodule // tre_bank

// file: verif/tre_bank_chk.sv
// port assertions for the tag ram error bank
`timescale 1ns/1ps
module tre_bank_chk (
   input wire clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire ram_req,
   input wire ram_ack,
   input wire [1:0] ram_way,
   input wire [8:0] ram_index
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence apb_take;
      psel && penable && !pready;
   endsequence
   sequence op_take;
      apb_take ##0 (pwrite && paddr == 12'h008 && !ram_req &&
         !$past(ram_req));
   endsequence
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held high");
   a_ready_wait: assert property (apb_take |=> pready)
      else $error("no answer one cycle after access");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_unmapped: assert property (apb_take ##0 paddr >= 12'h01C |=> pslverr)
      else $error("unmapped access not refused");
   a_op_start: assert property (op_take |-> ##[1:3] ram_req)
      else $error("operation write started no access");
   a_req_hold: assert property (ram_req && !ram_ack |=>
      ram_req && $stable(ram_way) && $stable(ram_index))
      else $error("access dropped or changed before ack");
   a_req_drop: assert property (ram_req && ram_ack |=> !ram_req)
      else $error("access held after ack");
endmodule // tre_bank_chk
bind tre_bank tre_bank_chk u_tre_bank_chk (.clk(clk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ram_req(ram_req), .ram_ack(ram_ack), .ram_way(ram_way),
   .ram_index(ram_index));

// file: verif/test_tre_bank.sv
// testbench for the tag ram error bank and debug access
`timescale 1ns/1ps
module test_tre_bank;
   reg clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er = 0;
   reg err_det = 0, err_cpu_seen = 0, ram_ack = 0, ram_valid_rd = 0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0, rd = 32'h0;
   reg [7:0] err_ways = 8'h00;
   reg [8:0] err_index = 9'h000;
   reg [4:0] ram_tag_rd = 5'h00;
   reg [6:0] ram_ecc_rd = 7'h00;
   reg [1:0] cnt = 2'h0;
   integer err_count = 0, n_tests = 0, i, k;
   wire [31:0] prdata;
   wire pready, pslverr, ram_req, ram_wr, ram_cpu, ram_valid_wr, irq;
   wire [1:0] ram_way;
   wire [8:0] ram_index;
   wire [4:0] ram_tag_wr;
   wire [6:0] ram_ecc_wr;
   always #4 clk = ~clk;
   tre_bank u_tre_bank (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .err_det(err_det), .err_cpu_seen(err_cpu_seen), .err_ways(err_ways),
      .err_index(err_index), .ram_req(ram_req), .ram_wr(ram_wr),
      .ram_cpu(ram_cpu), .ram_way(ram_way), .ram_index(ram_index),
      .ram_valid_wr(ram_valid_wr), .ram_tag_wr(ram_tag_wr),
      .ram_ecc_wr(ram_ecc_wr), .ram_ack(ram_ack),
      .ram_valid_rd(ram_valid_rd), .ram_tag_rd(ram_tag_rd),
      .ram_ecc_rd(ram_ecc_rd), .irq(irq));
   // ram stand-in: ack after three cycles; data toggles when not valid
   always @(posedge clk) begin
      cnt <= (ram_req && !ram_ack) ? cnt + 2'h1 : 2'h0;
      ram_ack <= cnt == 2'h2;
      ram_valid_rd <= cnt == 2'h2 ? 1'h1 : ~ram_valid_rd;
      ram_tag_rd <= cnt == 2'h2 ? 5'h15 : ~ram_tag_rd;
      ram_ecc_rd <= cnt == 2'h2 ? 7'h5A : ~ram_ecc_rd;
   end
   task conclude;
      begin
         $display("tests %0d mismatches %0d", n_tests, err_count);
         if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task hang;
      begin
         i = i + 1;
         if (i > 40) begin
            err_count = err_count + 1;
            conclude;
         end
         @(posedge clk);
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge clk);
         psel <= 1'h1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'h1;
         @(posedge clk);
         i = 0;
         while (pready !== 1'h1) hang;
         rd = prdata;
         er = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
      end
   endtask
   task rdc(input [11:0] a, input [31:0] exp);
      begin
         apb(1'h0, a, 32'h0);
         chk(rd, exp);
      end
   endtask
   task waitreq(input v);
      begin
         i = 0;
         while (ram_req !== v) hang;
      end
   endtask
   // one error event; the seen level is left standing on purpose
   task ev(input [7:0] w, input [8:0] x, input s);
      begin
         @(posedge clk);
         err_det <= 1'h1;
         err_ways <= w;
         err_index <= x;
         err_cpu_seen <= s;
         @(posedge clk);
         err_det <= 1'h0;
      end
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      for (k = 0; k < 7; k = k + 1) rdc({k[9:0], 2'h0}, 32'h0);
      rdc(12'h01C, 32'h0);
      chk({31'h0, er}, 32'h1);
      $display("reset and map test done");
      apb(1'h1, 12'h00C, 32'hFFFFFFFF);
      rdc(12'h00C, 32'h007E0000);
      apb(1'h1, 12'h010, 32'hFFFFFFFF);
      rdc(12'h010, 32'h0000007F);
      apb(1'h1, 12'h008, 32'hFFFFFFFF);
      waitreq(1'h1);
      chk({ram_way, ram_cpu, ram_index, ram_wr}, 32'h1FFF);
      chk({ram_valid_wr, ram_tag_wr, ram_ecc_wr}, 32'h1FFF);
      waitreq(1'h0);
      rdc(12'h008, 32'hC1003FE1);
      apb(1'h1, 12'h008, 32'h400002A0);
      waitreq(1'h1);
      chk({ram_way, ram_cpu, ram_index, ram_wr}, 32'h082A);
      waitreq(1'h0);
      rdc(12'h00C, 32'h006A0000);
      rdc(12'h010, 32'h0000005A);
      $display("debug access test done");
      rdc(12'h014, 32'h0000000C);
      rdc(12'h014, 32'h0);
      ev(8'hA5, 9'h1C3, 1'h0);
      rdc(12'h000, 32'h00A53861);
      ev(8'h3C, 9'h007, 1'h1);
      rdc(12'h004, 32'h003C00E2);
      rdc(12'h000, 32'h00A53862);
      ev(8'h11, 9'h0FF, 1'h1);
      rdc(12'h004, 32'h003C00E2);
      chk({31'h0, irq}, 32'h0);
      apb(1'h1, 12'h018, 32'h3);
      @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rdc(12'h014, 32'h3);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      apb(1'h1, 12'h000, 32'hFFA53863);
      rdc(12'h000, 32'h00A53863);
      apb(1'h1, 12'h000, 32'h0);
      rdc(12'h000, 32'h0);
      ev(8'h5A, 9'h100, 1'h0);
      rdc(12'h000, 32'h005A2001);
      $display("error bank and interrupt test done");
      conclude;
   end
endmodule // test_tre_bank
